// File: common/reset_ctrl_pkg.sv
// Package for the system reset controller: cause flag layout, vectors, timing counts.
// Assumes a single 100 MHz reference clock; every count is in clock cycles.
package reset_ctrl_pkg;

  // ----------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] NORMAL_VECTOR = 16'hFFFE;
  localparam logic [15:0] MONITOR_VECTOR = 16'hFEFE;

  // ----------------------------------------------------------------
  // Cause flag positions and reset value
  // ----------------------------------------------------------------
  localparam int CAUSE_W = 7;
  localparam int FLAG_POWER = 0;
  localparam int FLAG_PIN = 1;
  localparam int FLAG_WATCHDOG = 2;
  localparam int FLAG_BAD_OPCODE = 3;
  localparam int FLAG_BAD_FETCH = 4;
  localparam int FLAG_BROWNOUT = 5;
  localparam int FLAG_MONITOR = 6;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 7'h01;

  // ----------------------------------------------------------------
  // Timing counts (cycles of the reference clock), counter widths and the service clear bit
  // ----------------------------------------------------------------
  localparam int SYS_CNT_W = 12;
  localparam int STABILISE_CYCLES = 4096;
  localparam int PIN_DRIVE_CYCLES = 32;
  localparam int RELEASE_CYCLES = 32;
  localparam int SHORT_STOP_CYCLES = 32;
  localparam int MIN_LOW_CYCLES = 4;
  localparam int SERVICE_CLEAR_LSB = 5;
  localparam int WATCHDOG_W = 6;

  // Strobes from the CPU side: reset causes and the watchdog service write
  typedef struct packed {
    logic illegal_opcode;
    logic stop_executed;
    logic opcode_fetch;
    logic unmapped_access;
    logic service_write;
  } cpu_event_s;

  typedef enum logic [1:0] {
    RUN,
    LONG_DRIVE,
    SHORT_DRIVE,
    HOLD
  } seq_state_e;

endpackage

// File: logic/system_reset_controller.sv
// System reset controller: gathers reset sources, drives the shared reset pin and internal
// reset, keeps the cause flags, the 12-bit system counter and the watchdog.
// Assumes all inputs are synchronous to ref_clk and the CPU strobes last one cycle.
`timescale 1ns/1ps

// Notes on behaviour
// - Every reset asserts internal reset; vector is top pair, or one page lower in monitor.
// - Internal reset held while sequencing returns everything to defaults.
// - Internal sources clear the system counter; pin-only reset leaves it alone.
// - Each source sets its own cause flag.
// - Pin held low 4 cycles halts processing; pin flag needs minimum low time and no other source.
// - Power/brownout recovery lasts 4160 cycles, other internal sources 64.
// - Internal sources drive the pin 32 cycles, then hold internal reset 32 more.
// - Power/brownout drive the pin 4096+32 cycles, then the normal release.
// - At power-on clockgen output on, CPU clocks held off 4160 cycles.
// - Power-on sets its flag and clears all others not raised in the same cycle.
// - Watchdog overflow resets and sets the watchdog flag.
// - Service write clears watchdog counter and system counter bits 11 to 5.
// - System counter overflow clocks the watchdog.
// - Watchdog disabled only by test voltage in monitor or break gating.
// - Illegal instruction sets bad-opcode flag and resets.
// - Stop with stop disabled is an illegal-opcode reset.
// - Opcode fetch from unmapped address resets; data access does not.
// - Brownout sets its flag, drives pin 4096+32, releases 32 later.
// - Monitor-entry reset input causes internal reset with pin pulled low.
// - System counter is 12 bits; overflow feeds the watchdog.
// - Stop clears the system counter; it runs free after reset.
// - Stop exit delay is 32 cycles with short option, else 4096.
// - After stop exit CPU clocks stay off until the stop delay ends.
module system_reset_controller
  import reset_ctrl_pkg::*;
#(
  parameter int STABILISE = STABILISE_CYCLES,
  parameter int WDOG_W = WATCHDOG_W
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Reset sources
  input wire logic power_on,
  input wire logic brownout,
  input wire logic monitor_entry_reset,
  input wire cpu_event_s cpu_event,
  // Options and modes
  input wire logic stop_enable_opt,
  input wire logic short_recovery_opt,
  input wire logic monitor_mode,
  input wire logic break_state,
  input wire logic test_high_voltage_rst,
  input wire logic test_high_voltage_irq,
  input wire logic stop_wake,
  // Shared open-drain reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  // To CPU and modules
  output logic internal_reset,
  output logic [15:0] start_vector,
  output logic clockgen_output,
  output logic internal_bus_clocks,
  output logic [CAUSE_W-1:0] reset_cause_register,
  output logic [SYS_CNT_W-1:0] system_count
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (STABILISE < 1 || STABILISE > 4096) begin : g_bad_stab
    $error("STABILISE must be 1..4096");
  end
  if (WDOG_W < 1 || WDOG_W > 16) begin : g_bad_wdog
    $error("WDOG_W must be 1..16");
  end

  localparam logic [SYS_CNT_W:0] STAB_N = (SYS_CNT_W+1)'(STABILISE);
  localparam logic [SYS_CNT_W:0] DRIVE_N = (SYS_CNT_W+1)'(PIN_DRIVE_CYCLES);
  localparam logic [SYS_CNT_W:0] REL_N = (SYS_CNT_W+1)'(RELEASE_CYCLES);
  localparam logic [SYS_CNT_W:0] SHORT_N = (SYS_CNT_W+1)'(SHORT_STOP_CYCLES);
  localparam logic [3:0] MIN_LOW_N = 4'(MIN_LOW_CYCLES);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_e seq;
    logic [SYS_CNT_W:0] phase;
    logic [SYS_CNT_W-1:0] sys_cnt;
    logic [WDOG_W-1:0] wdog;
    logic [CAUSE_W-1:0] cause;
    logic [3:0] pin_low;
    logic pin_reset;
    logic stopped;
    logic stop_wait;
    logic [SYS_CNT_W:0] stop_cnt;
    logic bus_on;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic wdog_disable;
  logic wdog_tick;
  logic wdog_over;
  logic bad_op;
  logic bad_fetch;
  logic long_src;
  logic short_src;
  logic [CAUSE_W-1:0] hits;

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  // Only pure gating on the test voltage may disable the watchdog, so noise cannot latch it
  assign wdog_disable = (monitor_mode & (test_high_voltage_rst | test_high_voltage_irq))
                      | (break_state & test_high_voltage_rst);
  assign wdog_tick = (cur.sys_cnt == '1);
  assign wdog_over = wdog_tick & (cur.wdog == '1) & ~wdog_disable
                   & ~cpu_event.service_write;
  assign bad_op = cpu_event.illegal_opcode
                | (cpu_event.stop_executed & ~stop_enable_opt);
  assign bad_fetch = cpu_event.opcode_fetch & cpu_event.unmapped_access;
  assign long_src = power_on | brownout;
  assign short_src = wdog_over | bad_op | bad_fetch | monitor_entry_reset;

  // Cause bits of all sources except the pin active this cycle
  always_comb begin
    hits = '0;
    hits[FLAG_POWER] = power_on;
    hits[FLAG_BROWNOUT] = brownout;
    hits[FLAG_WATCHDOG] = wdog_over;
    hits[FLAG_BAD_OPCODE] = bad_op;
    hits[FLAG_BAD_FETCH] = bad_fetch;
    hits[FLAG_MONITOR] = monitor_entry_reset;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // System counter free-runs; service clears its upper bits and the watchdog
    next_cur.sys_cnt = cur.sys_cnt + 1'b1;
    if (wdog_tick && !wdog_disable) begin
      next_cur.wdog = cur.wdog + 1'b1;
    end
    if (cpu_event.service_write) begin
      next_cur.sys_cnt[SYS_CNT_W-1:SERVICE_CLEAR_LSB] = '0;
      next_cur.wdog = '0;
    end
    if (cpu_event.stop_executed && stop_enable_opt) begin
      next_cur.sys_cnt = '0;
      next_cur.stopped = 1'b1;
      next_cur.bus_on = 1'b0;
    end
    // Stop exit: counter clocked, bus clocks wait for the chosen delay
    if (cur.stopped && stop_wake) begin
      next_cur.stopped = 1'b0;
      next_cur.stop_wait = 1'b1;
      next_cur.stop_cnt = short_recovery_opt ? SHORT_N : STAB_N;
    end
    if (cur.stop_wait) begin
      next_cur.stop_cnt = cur.stop_cnt - 1'b1;
      if (cur.stop_cnt == 1) begin
        next_cur.stop_wait = 1'b0;
        next_cur.bus_on = 1'b1;
      end
    end
    // Pin low time; the flag waits until no other source is present
    next_cur.pin_low = reset_pin_in ? 4'h0 :
                       (cur.pin_low == MIN_LOW_N ? cur.pin_low : cur.pin_low + 4'h1);
    // Flags from this cycle accumulate while a sequence runs
    if (|hits) begin
      next_cur.cause = cur.cause | hits;
      if (power_on) begin
        next_cur.cause = hits;
      end
    end
    // Sequencer
    unique case (cur.seq)
      RUN: begin
        // Stop entry and exit above own the bus clocks here; a new sequence stops them
        if (long_src) begin
          next_cur.seq = LONG_DRIVE;
          next_cur.phase = STAB_N + DRIVE_N;
          next_cur.bus_on = 1'b0;
        end else if (short_src) begin
          next_cur.seq = SHORT_DRIVE;
          next_cur.phase = DRIVE_N;
          next_cur.bus_on = 1'b0;
        end else if (cur.pin_low == MIN_LOW_N) begin
          next_cur.seq = HOLD;
          next_cur.bus_on = 1'b0;
          next_cur.phase = REL_N;
          next_cur.pin_reset = 1'b1;
          next_cur.cause = {CAUSE_W{1'b0}} | (CAUSE_W'(1) << FLAG_PIN);
        end
      end
      LONG_DRIVE, SHORT_DRIVE: begin
        next_cur.bus_on = 1'b0;
        next_cur.stopped = 1'b0;
        next_cur.stop_wait = 1'b0;
        next_cur.phase = cur.phase - 1'b1;
        if (long_src && cur.seq == SHORT_DRIVE) begin
          next_cur.seq = LONG_DRIVE;
          next_cur.phase = STAB_N + DRIVE_N;
        end else if (cur.phase == 1) begin
          next_cur.seq = HOLD;
          next_cur.phase = REL_N;
        end
      end
      HOLD: begin
        next_cur.bus_on = 1'b0;
        next_cur.phase = cur.phase - 1'b1;
        if (long_src) begin
          next_cur.seq = LONG_DRIVE;
          next_cur.phase = STAB_N + DRIVE_N;
          next_cur.pin_reset = 1'b0;
        end else if (short_src) begin
          next_cur.seq = SHORT_DRIVE;
          next_cur.phase = DRIVE_N;
          next_cur.pin_reset = 1'b0;
        end else if (!reset_pin_in) begin
          next_cur.phase = REL_N;
        end else if (cur.phase == 1) begin
          next_cur.seq = RUN;
          next_cur.bus_on = 1'b1;
          next_cur.pin_reset = 1'b0;
        end
      end
    endcase
    // Internal sources restart the counter; a pin-only reset leaves it
    if (short_src || long_src) begin
      next_cur.sys_cnt = '0;
      next_cur.wdog = '0;
    end
    if (cur.seq != RUN && !cur.pin_reset) begin
      next_cur.sys_cnt = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register; reset behaves as a power-on
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur.seq <= LONG_DRIVE;
      cur.phase <= STAB_N + DRIVE_N;
      cur.sys_cnt <= '0;
      cur.wdog <= '0;
      cur.cause <= CAUSE_RESET;
      cur.pin_low <= 4'h0;
      cur.pin_reset <= 1'b0;
      cur.stopped <= 1'b0;
      cur.stop_wait <= 1'b0;
      cur.stop_cnt <= '0;
      cur.bus_on <= 1'b0;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin pulled low only during the drive phases; open drain, enable active low
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n = ~(cur.seq == LONG_DRIVE || cur.seq == SHORT_DRIVE);
  assign internal_reset = (cur.seq != RUN);
  assign start_vector = monitor_mode ? MONITOR_VECTOR : NORMAL_VECTOR;
  assign clockgen_output = 1'b1;
  assign internal_bus_clocks = cur.bus_on;
  assign reset_cause_register = cur.cause;
  assign system_count = cur.sys_cnt;

endmodule

// File: sim/reset_line_partner.sv
// Model of another chip on the shared open-drain reset line.
// Assumes a pull-up on the line and a controller that only ever drives low.
`timescale 1ns/1ps
module reset_line_partner (
  // Controller side
  input wire logic reset_pin_oe_n,
  input wire logic reset_pin_out,
  // Request from the far chip to pull the line low
  input wire logic pull_low,
  // Resolved line level
  output logic reset_pin_in
);
  // ------------------------------------------------------------
  // Wired-AND with pull-up
  // ------------------------------------------------------------
  // A released line returns to the pull-up level, never to a stale value
  assign reset_pin_in = ((!reset_pin_oe_n && !reset_pin_out) || pull_low) ? 1'b0 : 1'b1;
endmodule

// File: sim/system_reset_controller_assertions.sv
// Port checks for the system reset controller.
// Assumes clk_en stays high and the far chip leaves the line alone in the hold phase.
`timescale 1ns/1ps
module system_reset_controller_assertions
  import reset_ctrl_pkg::*;
#(
  parameter int STABILISE = STABILISE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Inputs watched
  input wire logic clk_en,
  input wire cpu_event_s cpu_event,
  input wire logic stop_enable_opt,
  input wire logic monitor_mode,
  // Outputs watched
  input wire logic reset_pin_oe_n,
  input wire logic internal_reset,
  input wire logic [15:0] start_vector,
  input wire logic internal_bus_clocks,
  input wire logic [CAUSE_W-1:0] reset_cause_register,
  input wire logic [SYS_CNT_W-1:0] system_count
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  int low_cnt;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Length of the current pin drive; a counter avoids long repetitions
  always_ff @(posedge ref_clk) begin
    low_cnt <= (rst || reset_pin_oe_n) ? 0 : low_cnt + 1;
  end
  sequence trapped_s;
    !reset_pin_oe_n && internal_reset;
  endsequence
  sequence hold_s;
    internal_reset ##31 internal_reset ##1 !internal_reset;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  vector_select_a: assert property (start_vector == (monitor_mode ? 16'hFEFE : 16'hFFFE))
    else $error("start vector wrong for mode");
  opcode_trap_a: assert property (clk_en && !internal_reset && cpu_event.illegal_opcode |=>
    trapped_s and (reset_cause_register[FLAG_BAD_OPCODE] && system_count == 12'h000))
    else $error("bad opcode did not reset");
  stop_trap_a: assert property (clk_en && !internal_reset && cpu_event.stop_executed &&
    !stop_enable_opt |=> trapped_s and reset_cause_register[FLAG_BAD_OPCODE])
    else $error("disabled stop did not reset");
  fetch_trap_a: assert property (clk_en && !internal_reset && cpu_event.opcode_fetch &&
    cpu_event.unmapped_access |=> trapped_s and reset_cause_register[FLAG_BAD_FETCH])
    else $error("unmapped fetch did not reset");
  service_clear_a: assert property (clk_en && !internal_reset && cpu_event.service_write
    |=> system_count[11:5] == 7'h00)
    else $error("service write left upper count");
  drive_len_a: assert property ($rose(reset_pin_oe_n) |-> low_cnt == 32 || low_cnt >= STABILISE)
    else $error("pin drive length wrong");
  hold_len_a: assert property ($rose(reset_pin_oe_n) |-> hold_s)
    else $error("internal reset hold length wrong");
  bus_gate_a: assert property (internal_reset |-> !internal_bus_clocks)
    else $error("bus clocks run in reset");
endmodule
bind system_reset_controller system_reset_controller_assertions #(.STABILISE(STABILISE)) u_chk (.*);

// File: sim/system_reset_controller_bench.sv
// Self-checking bench for the system reset controller.
// Assumes the package, the line partner and the checker are compiled first.
`timescale 1ns/1ps
module system_reset_controller_bench;
  import reset_ctrl_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int STABILISE = 64; // Short so long sequences stay quick
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, pull_low = 1'b0;
  logic power_on = 1'b0, brownout = 1'b0, monitor_entry_reset = 1'b0, stop_wake = 1'b0;
  logic stop_enable_opt = 1'b1, short_recovery_opt = 1'b1, monitor_mode = 1'b0;
  logic break_state = 1'b0, test_high_voltage_rst = 1'b0, test_high_voltage_irq = 1'b0;
  logic reset_pin_in, reset_pin_out, reset_pin_oe_n, internal_reset;
  logic clockgen_output, internal_bus_clocks;
  logic [15:0] start_vector;
  logic [CAUSE_W-1:0] reset_cause_register;
  logic [SYS_CNT_W-1:0] system_count;
  cpu_event_s cpu_event = '0;
  int num_errors = 0, n_compared = 0, seed = 62764, d, h, exp_cause;
  int flag_of[6] = '{3, 3, 4, 6, 5, 0};
  // One-bit watchdog so an expiry fits in the run
  system_reset_controller #(.STABILISE(STABILISE), .WDOG_W(1)) i_dut (.*);
  reset_line_partner i_line (.*);
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  // One-cycle pulse on a source, with a random mode for the vector
  task fire(input int i);
    @(posedge ref_clk);
    monitor_mode <= 1'($random(seed));
    stop_enable_opt <= (i != 1);
    case (i)
      0: cpu_event.illegal_opcode <= 1'b1;
      1, 8: cpu_event.stop_executed <= 1'b1;
      2: cpu_event.opcode_fetch <= 1'b1;
      3: monitor_entry_reset <= 1'b1;
      4: brownout <= 1'b1;
      5: power_on <= 1'b1;
      6: cpu_event.unmapped_access <= 1'b1;
      7: cpu_event.service_write <= 1'b1;
      default: stop_wake <= 1'b1;
    endcase
    if (i == 2) cpu_event.unmapped_access <= 1'b1;
    @(posedge ref_clk);
    cpu_event <= '0;
    {monitor_entry_reset, brownout, power_on, stop_wake} <= 4'h0;
    #1;
  endtask
  // Bounded wait while internal reset sits at a level; h gives the length
  task wait_on(input logic lvl);
    h = 0;
    while (internal_reset === lvl && h < 10000) begin
      h++;
      tick;
    end
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    tick;
    wait_on(1'b1);
    exp_cause = 1;
    chk(reset_cause_register, exp_cause);
    chk(internal_bus_clocks, 1'b1);
    chk(clockgen_output, 1'b1);
    chk(reset_pin_out, 1'b0);
    // Every source except the watchdog and the pin; flags build up until power-on clears them
    for (int i = 0; i < 6; i++) begin
      fire(i);
      chk(system_count, 12'h000);
      d = 0;
      while (!reset_pin_oe_n && d < 9000) begin
        d++;
        tick;
      end
      wait_on(1'b1);
      chk(16'(d), 16'((i > 3) ? STABILISE + 32 : 32));
      chk(16'(h), 16'd32);
      exp_cause = (i == 5) ? 1 : exp_cause | (1 << flag_of[i]);
      chk(reset_cause_register, exp_cause);
      chk(start_vector, monitor_mode ? 16'hFEFE : 16'hFFFE);
    end
    fire(6);
    repeat (3) tick;
    chk(internal_reset, 1'b0);
    fire(7);
    chk(system_count[11:5], 7'h00);
    // Pin held low too briefly, then long enough; pin flag replaces the rest
    for (int n = 2; n < 7; n += 4) begin
      @(posedge ref_clk);
      pull_low <= 1'b1;
      repeat (n) @(posedge ref_clk);
      pull_low <= 1'b0;
      tick;
      wait_on(1'b1);
      exp_cause = (n > 4) ? 2 : exp_cause;
      chk(reset_cause_register, exp_cause);
    end
    // Stop recovery with the short and the long delay
    for (int o = 1; o >= 0; o--) begin
      short_recovery_opt <= o[0];
      fire(8);
      chk(system_count, 12'h000);
      fire(9);
      d = 0;
      while (!internal_bus_clocks && d < 9000) begin
        d++;
        tick;
      end
      chk(d + 2 >= (o ? 32 : STABILISE) && d <= (o ? 34 : STABILISE + 2), 1'b1);
    end
    // Watchdog held off by the test voltage, then left to expire
    monitor_mode <= 1'b1;
    test_high_voltage_rst <= 1'b1;
    repeat (9000) tick;
    chk(internal_reset, 1'b0);
    test_high_voltage_rst <= 1'b0;
    wait_on(1'b0);
    chk(reset_cause_register[FLAG_WATCHDOG], 1'b1);
    wait_on(1'b1);
    tally_and_finish;
  end
  // Watchdog on the run itself: about three times the expected length
  initial begin
    #600000;
    num_errors++;
    tally_and_finish;
  end
endmodule
